// [io_bank_map.svh]
// Address map, reset values and interrupt vectors of the I/O register bank.
// Assumes a 12-bit data address and 4-bit data words from the CPU core.
`ifndef IO_BANK_MAP_SVH
`define IO_BANK_MAP_SVH
`define IO_PAGE           6'h3C
`define ADR_CLK_FLAGS     12'hF00
`define ADR_SW_FLAGS      12'hF01
`define ADR_PT_FLAG       12'hF02
`define ADR_SIO_FLAG      12'hF03
`define ADR_K0_FLAG       12'hF04
`define ADR_K1_FLAG       12'hF05
`define ADR_CLK_MASK      12'hF10
`define ADR_SW_MASK       12'hF11
`define ADR_PT_MASK       12'hF12
`define ADR_SIO_MASK      12'hF13
`define ADR_K0_MASK       12'hF14
`define ADR_K1_MASK       12'hF15
`define ADR_DIV_HIGH      12'hF20
`define ADR_DIV_LOW       12'hF21
`define ADR_SW_HUND       12'hF22
`define ADR_SW_TENTH      12'hF23
`define ADR_PT_CNT_LO     12'hF24
`define ADR_PT_CNT_HI     12'hF25
`define ADR_PT_RLD_LO     12'hF26
`define ADR_PT_RLD_HI     12'hF27
`define ADR_SIO_LO        12'hF30
`define ADR_SIO_HI        12'hF31
`define ADR_K0_LEVELS     12'hF40
`define FLAG_RESET        4'h0
`define MASK_RESET        4'h0
`define VEC_CLOCK         12'h102
`define VEC_STOPWATCH     12'h104
`define VEC_INPUT0        12'h106
`define VEC_INPUT1        12'h108
`define VEC_SERIAL        12'h10A
`define VEC_PROG_TIMER    12'h10C
`define VEC_NONE          12'h000
`endif

// [io_bank_pkg.sv]
// Types shared by the I/O register bank and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package io_bank_pkg;
  // One CPU data memory access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  wdata;
  } mem_req_t;
  // Event pulses from the peripheral functions
  typedef struct packed {
    logic [3:0] clk_ev;
    logic [1:0] sw_ev;
    logic       pt_ev;
    logic       sio_ev;
    logic       k0_ev;
    logic       k1_ev;
  } irq_ev_t;
endpackage

// [irq_flag_slice.sv]
// One group of sticky interrupt factor flags with clear-on-read.
// Assumes set and read-clear are single-cycle pulses on clk_sys.
module irq_flag_slice #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Events and read strobe
  input  wire logic [WIDTH-1:0] set_ev,
  input  wire logic             rd_clr,
  // Flag state
  output logic      [WIDTH-1:0] flags_ff
);
  // A set in the read cycle survives so the event is not lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_ff <= '0;
    end else if (rd_clr) begin
      flags_ff <= set_ev;
    end else begin
      flags_ff <= flags_ff | set_ev;
    end
  end
endmodule

// [io_bank.sv]
// I/O data memory register bank: flags, masks, timer readouts, data regs.
// Assumes the CPU core gives one-cycle rd/wr strobes with a 12-bit address
// and takes read data one cycle later; peripherals drive state inputs.
// How it works
// - Each interrupt factor flag clears when its register is read.
// - Unused bits in flag and mask registers read zero, no storage.
// - CLOCK_TIMER_IRQ_FLAGS holds clock timer flags 1, 2, 8, 32 Hz in D3..D0, reset 0.
// - STOPWATCH_IRQ_FLAGS holds stopwatch 1 Hz flag in D1, 10 Hz in D0, reset 0.
// - PROG_TIMER_IRQ_FLAG D0 is the programmable timer flag, reset 0.
// - SERIAL_IRQ_FLAG D0 is the serial interface flag, reset 0.
// - INPUT_GROUP0_IRQ_FLAG D0 and INPUT_GROUP1_IRQ_FLAG D0 flag input group zero and one, reset 0.
// - CLOCK_TIMER_IRQ_MASK holds four writable clock timer masks, 1 enables, reset 0.
// - STOPWATCH_IRQ_MASK..SERIAL_IRQ_MASK hold stopwatch, timer, serial enables, reset masked.
// - INPUT_GROUP0_IRQ_MASK and INPUT_GROUP1_IRQ_MASK hold one enable per input pin, reset masked.
// - CLOCK_DIVIDER_HIGH_RATE and CLOCK_DIVIDER_LOW_RATE read the clock divider stages, reset 0.
// - STOPWATCH_HUNDREDTHS reads the stopwatch hundredths BCD digit.
// - PROG_TIMER_COUNT_LOW and PROG_TIMER_COUNT_HIGH read the programmable timer count nibbles.
// - PROG_TIMER_RELOAD_LOW and PROG_TIMER_RELOAD_HIGH hold the writable timer reload value.
// - SERIAL_SHIFT_DATA_LOW and SERIAL_SHIFT_DATA_HIGH hold the writable serial data register.
// - INPUT_GROUP0_LEVELS reads the live levels of input group zero.
// - The bank decodes 192 words at the bottom of the F page, F00H..FBFH.
// - Vectors 102H..10CH, programmable timer highest, clock lowest.

`include "io_bank_map.svh"
module io_bank
  import io_bank_pkg::*;
#(
  parameter int DW = 4
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // CPU data memory access
  input  wire mem_req_t      req,
  output logic    [DW-1:0]   rdata_ff,
  output logic               rvalid_ff,
  output logic               hit_ff,
  // Peripheral events and state
  input  wire irq_ev_t       ev,
  input  wire logic [7:0]    divider,
  input  wire logic [3:0]    sw_hund,
  input  wire logic [3:0]    sw_tenth,
  input  wire logic [7:0]    pt_count,
  input  wire logic [7:0]    sio_load,
  input  wire logic          sio_load_en,
  input  wire logic [3:0]    k0_pins,
  input  wire logic [3:0]    k1_pins,
  // Register outputs to peripherals
  output logic [7:0]         pt_reload_ff,
  output logic [7:0]         sio_data_ff,
  // Interrupt request to the core
  output logic               irq_ff,
  output logic [11:0]        irq_vec_ff
);

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  logic       in_bank;
  logic       rd_hit;
  logic       wr_hit;
  // Bank spans CLOCK_TIMER_IRQ_FLAGS..FBFH; the top quarter of the F page stays unmapped,
  // so reads there return zero and never raise a hit
  assign in_bank = (req.addr[11:8] == 4'hF) && (req.addr[7:6] != 2'h3);
  assign rd_hit  = req.rd && in_bank;
  assign wr_hit  = req.wr && in_bank;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt factor flags
  logic [3:0] clk_flags;
  logic [1:0] sw_flags;
  logic [0:0] pt_flag;
  logic [0:0] sio_flag;
  logic [0:0] k0_flag;
  logic [0:0] k1_flag;
  logic [3:0] k0_pins_d_ff;
  logic [3:0] k1_pins_d_ff;
  logic       k0_ev_all;
  logic       k1_ev_all;

  // Each flag group sits behind its own clear-on-read slice
  irq_flag_slice #(.WIDTH(4)) u_clk (
    .clk_sys(clk_sys), .rst(rst), .set_ev(ev.clk_ev),
    .rd_clr(rd_hit && req.addr == `ADR_CLK_FLAGS), .flags_ff(clk_flags)
  );
  irq_flag_slice #(.WIDTH(2)) u_sw (
    .clk_sys(clk_sys), .rst(rst), .set_ev(ev.sw_ev),
    .rd_clr(rd_hit && req.addr == `ADR_SW_FLAGS), .flags_ff(sw_flags)
  );
  irq_flag_slice #(.WIDTH(1)) u_pt (
    .clk_sys(clk_sys), .rst(rst), .set_ev(ev.pt_ev),
    .rd_clr(rd_hit && req.addr == `ADR_PT_FLAG), .flags_ff(pt_flag)
  );
  irq_flag_slice #(.WIDTH(1)) u_sio (
    .clk_sys(clk_sys), .rst(rst), .set_ev(ev.sio_ev),
    .rd_clr(rd_hit && req.addr == `ADR_SIO_FLAG), .flags_ff(sio_flag)
  );
  irq_flag_slice #(.WIDTH(1)) u_k0 (
    .clk_sys(clk_sys), .rst(rst), .set_ev(k0_ev_all),
    .rd_clr(rd_hit && req.addr == `ADR_K0_FLAG), .flags_ff(k0_flag)
  );
  irq_flag_slice #(.WIDTH(1)) u_k1 (
    .clk_sys(clk_sys), .rst(rst), .set_ev(k1_ev_all),
    .rd_clr(rd_hit && req.addr == `ADR_K1_FLAG), .flags_ff(k1_flag)
  );

  // Previous pin levels for per-pin edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      k0_pins_d_ff <= 4'h0;
      k1_pins_d_ff <= 4'h0;
    end else begin
      k0_pins_d_ff <= k0_pins;
      k1_pins_d_ff <= k1_pins;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt masks
  logic [3:0] clk_mask_ff;
  logic [1:0] sw_mask_ff;
  logic       pt_mask_ff;
  logic       sio_mask_ff;
  logic [3:0] k0_mask_ff;
  logic [3:0] k1_mask_ff;

  // Pin events count only on enabled pins; external event strobes also
  // accepted so the port logic may decide edges on its own
  assign k0_ev_all = ev.k0_ev | (|(k0_mask_ff & (k0_pins ^ k0_pins_d_ff)));
  assign k1_ev_all = ev.k1_ev | (|(k1_mask_ff & (k1_pins ^ k1_pins_d_ff)));

  // Only implemented bits have storage; the rest are dropped on write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_mask_ff <= `MASK_RESET;
      sw_mask_ff  <= 2'h0;
      pt_mask_ff  <= 1'b0;
      sio_mask_ff <= 1'b0;
      k0_mask_ff  <= `MASK_RESET;
      k1_mask_ff  <= `MASK_RESET;
    end else if (wr_hit) begin
      unique case (req.addr)
        `ADR_CLK_MASK: clk_mask_ff <= req.wdata;
        `ADR_SW_MASK:  sw_mask_ff  <= req.wdata[1:0];
        `ADR_PT_MASK:  pt_mask_ff  <= req.wdata[0];
        `ADR_SIO_MASK: sio_mask_ff <= req.wdata[0];
        `ADR_K0_MASK:  k0_mask_ff  <= req.wdata;
        `ADR_K1_MASK:  k1_mask_ff  <= req.wdata;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reload and serial data registers
  // Reset value is free; cleared so reads after reset are never unknown
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pt_reload_ff <= 8'h00;
    end else if (wr_hit && req.addr == `ADR_PT_RLD_LO) begin
      pt_reload_ff[3:0] <= req.wdata;
    end else if (wr_hit && req.addr == `ADR_PT_RLD_HI) begin
      pt_reload_ff[7:4] <= req.wdata;
    end
  end

  // CPU write wins over a shifter load in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sio_data_ff <= 8'h00;
    end else if (wr_hit && req.addr == `ADR_SIO_LO) begin
      sio_data_ff[3:0] <= req.wdata;
    end else if (wr_hit && req.addr == `ADR_SIO_HI) begin
      sio_data_ff[7:4] <= req.wdata;
    end else if (sio_load_en) begin
      sio_data_ff <= sio_load;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [3:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 4'h0;
    unique case (req.addr)
      `ADR_CLK_FLAGS: nxt_rdata = clk_flags;
      `ADR_SW_FLAGS:  nxt_rdata = {2'h0, sw_flags};
      `ADR_PT_FLAG:   nxt_rdata = {3'h0, pt_flag};
      `ADR_SIO_FLAG:  nxt_rdata = {3'h0, sio_flag};
      `ADR_K0_FLAG:   nxt_rdata = {3'h0, k0_flag};
      `ADR_K1_FLAG:   nxt_rdata = {3'h0, k1_flag};
      `ADR_CLK_MASK:  nxt_rdata = clk_mask_ff;
      `ADR_SW_MASK:   nxt_rdata = {2'h0, sw_mask_ff};
      `ADR_PT_MASK:   nxt_rdata = {3'h0, pt_mask_ff};
      `ADR_SIO_MASK:  nxt_rdata = {3'h0, sio_mask_ff};
      `ADR_K0_MASK:   nxt_rdata = k0_mask_ff;
      `ADR_K1_MASK:   nxt_rdata = k1_mask_ff;
      `ADR_DIV_HIGH:  nxt_rdata = divider[3:0];
      `ADR_DIV_LOW:   nxt_rdata = divider[7:4];
      `ADR_SW_HUND:   nxt_rdata = sw_hund;
      `ADR_SW_TENTH:  nxt_rdata = sw_tenth;
      `ADR_PT_CNT_LO: nxt_rdata = pt_count[3:0];
      `ADR_PT_CNT_HI: nxt_rdata = pt_count[7:4];
      `ADR_PT_RLD_LO: nxt_rdata = pt_reload_ff[3:0];
      `ADR_PT_RLD_HI: nxt_rdata = pt_reload_ff[7:4];
      `ADR_SIO_LO:    nxt_rdata = sio_data_ff[3:0];
      `ADR_SIO_HI:    nxt_rdata = sio_data_ff[7:4];
      `ADR_K0_LEVELS: nxt_rdata = k0_pins;
      default:        nxt_rdata = 4'h0;
    endcase
  end

  // Read data registered; value is the pre-clear flag state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff  <= 4'h0;
      rvalid_ff <= 1'b0;
      hit_ff    <= 1'b0;
    end else begin
      rvalid_ff <= req.rd;
      hit_ff    <= rd_hit;
      rdata_ff  <= rd_hit ? nxt_rdata : 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt request and priority vector
  logic [5:0]  src_req;
  logic [11:0] nxt_vec;
  assign src_req[0] = |(clk_flags & clk_mask_ff);
  assign src_req[1] = |(sw_flags & sw_mask_ff);
  assign src_req[2] = k0_flag[0];
  assign src_req[3] = k1_flag[0];
  assign src_req[4] = sio_flag[0] & sio_mask_ff;
  assign src_req[5] = pt_flag[0] & pt_mask_ff;

  // Highest priority checked first
  always_comb begin
    if (src_req[5]) begin
      nxt_vec = `VEC_PROG_TIMER;
    end else if (src_req[4]) begin
      nxt_vec = `VEC_SERIAL;
    end else if (src_req[3]) begin
      nxt_vec = `VEC_INPUT1;
    end else if (src_req[2]) begin
      nxt_vec = `VEC_INPUT0;
    end else if (src_req[1]) begin
      nxt_vec = `VEC_STOPWATCH;
    end else if (src_req[0]) begin
      nxt_vec = `VEC_CLOCK;
    end else begin
      nxt_vec = `VEC_NONE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ff     <= 1'b0;
      irq_vec_ff <= `VEC_NONE;
    end else begin
      irq_ff     <= |src_req;
      irq_vec_ff <= nxt_vec;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  // Flags: a read answers with the state before its own clear
  read_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_CLK_FLAGS && ev.clk_ev == 4'h0)
    |=> clk_flags == 4'h0) else $error("flag not cleared by read");
  sw_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_SW_FLAGS && ev.sw_ev == 2'h0)
    |=> sw_flags == 2'h0) else $error("stopwatch flag not cleared");
  clk_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_CLK_FLAGS)
    |=> rdata_ff == $past(clk_flags)) else $error("bad clock flag read");
  read_sees_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_PT_FLAG)
    |=> rdata_ff == {3'h0, $past(pt_flag)}) else $error("bad flag read");
  unused_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_SW_MASK)
    |=> rdata_ff[3:2] == 2'h0) else $error("unused bits nonzero");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_SIO_FLAG && ev.sio_ev)
    |=> sio_flag[0]) else $error("event lost on clear");
  pin_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
    (k0_mask_ff[0] && (k0_pins[0] != k0_pins_d_ff[0]))
    |=> k0_flag[0]) else $error("pin edge not flagged");

  // Masks keep exactly the written implemented bits
  mask_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_hit && req.addr == `ADR_CLK_MASK)
    |=> clk_mask_ff == $past(req.wdata)) else $error("mask not written");
  sw_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_hit && req.addr == `ADR_SW_MASK)
    |=> sw_mask_ff == $past(req.wdata[1:0])) else $error("bad sw mask");
  pin_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_hit && req.addr == `ADR_K0_MASK)
    |=> k0_mask_ff == $past(req.wdata)) else $error("pin mask not written");

  // Readouts pass the live peripheral state of the read cycle
  div_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_DIV_HIGH)
    |=> rdata_ff == $past(divider[3:0])) else $error("bad divider read");
  hund_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_SW_HUND)
    |=> rdata_ff == $past(sw_hund)) else $error("bad hundredths read");
  tenth_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_SW_TENTH)
    |=> rdata_ff == $past(sw_tenth)) else $error("bad tenths read");
  count_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_PT_CNT_HI)
    |=> rdata_ff == $past(pt_count[7:4])) else $error("bad count read");
  pin_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_hit && req.addr == `ADR_K0_LEVELS)
    |=> rdata_ff == $past(k0_pins)) else $error("bad pin read");

  // Data registers take the written nibble on the next edge
  reload_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_hit && req.addr == `ADR_PT_RLD_LO)
    |=> pt_reload_ff[3:0] == $past(req.wdata))
    else $error("reload not written");
  serial_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_hit && req.addr == `ADR_SIO_HI)
    |=> sio_data_ff[7:4] == $past(req.wdata))
    else $error("serial data not written");
  miss_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (req.rd && !in_bank) |=> rdata_ff == 4'h0 && !hit_ff)
    else $error("miss returned data");

  // Request and vector follow the enabled flags and the unmasked input group flags one edge later
  masked_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (src_req == 6'h00) |=> !irq_ff) else $error("irq without source");
  irq_raised_a: assert property (@(posedge clk_sys) disable iff (rst)
    (src_req != 6'h00) |=> irq_ff) else $error("irq missing");
  top_prio_a: assert property (@(posedge clk_sys) disable iff (rst)
    src_req[5] |=> irq_ff && irq_vec_ff == `VEC_PROG_TIMER)
    else $error("wrong vector");
  low_prio_a: assert property (@(posedge clk_sys) disable iff (rst)
    (src_req == 6'h01) |=> irq_vec_ff == `VEC_CLOCK)
    else $error("wrong low vector");

  clk_irq_c: cover property (@(posedge clk_sys) disable iff (rst)
    src_req[0] ##1 irq_vec_ff == `VEC_CLOCK);
  clear_c: cover property (@(posedge clk_sys) disable iff (rst)
    rd_hit && req.addr == `ADR_CLK_FLAGS && clk_flags != 4'h0);
  coincide_c: cover property (@(posedge clk_sys) disable iff (rst)
    src_req[5] && src_req[0]);
  pin_edge_c: cover property (@(posedge clk_sys) disable iff (rst)
    k0_mask_ff[0] && (k0_pins[0] != k0_pins_d_ff[0]));
endmodule

// [tb_top.sv]
// Self-checking bench for the I/O register bank: flags, masks, readouts,
// data registers and the interrupt request. Assumes the bank's map header
// and package are compiled first; no partner model, the bench drives all.
`include "io_bank_map.svh"
module tb_top;
  import io_bank_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Bench signals, every design input driven from here
  logic           clk_sys;
  logic           rst;
  mem_req_t       req;
  irq_ev_t        ev;
  logic [7:0]     divider;
  logic [3:0]     sw_hund;
  logic [3:0]     sw_tenth;
  logic [7:0]     pt_count;
  logic [7:0]     sio_load;
  logic           sio_load_en;
  logic [3:0]     k0_pins;
  logic [3:0]     k1_pins;
  logic [3:0]     rdata_ff;
  logic           rvalid_ff;
  logic           hit_ff;
  logic [7:0]     pt_reload_ff;
  logic [7:0]     sio_data_ff;
  logic           irq_ff;
  logic [11:0]    irq_vec_ff;
  int             num_errors;
  int             compares;

  io_bank i_dut (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .hit_ff(hit_ff), .ev(ev), .divider(divider),
    .sw_hund(sw_hund), .sw_tenth(sw_tenth), .pt_count(pt_count),
    .sio_load(sio_load), .sio_load_en(sio_load_en), .k0_pins(k0_pins),
    .k1_pins(k1_pins), .pt_reload_ff(pt_reload_ff),
    .sio_data_ff(sio_data_ff), .irq_ff(irq_ff), .irq_vec_ff(irq_vec_ff)
  );

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison and bus tasks; strobes change on the falling edge
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read data is registered, so it is settled at the next falling edge
  task automatic rdchk(input logic [11:0] a, input logic [3:0] exp);
    @(negedge clk_sys);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_sys);
    req.rd = 1'b0;
    check({8'h00, rdata_ff}, {8'h00, exp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    @(negedge clk_sys);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask

  task automatic pulse(input irq_ev_t e);
    @(negedge clk_sys);
    ev = e;
    @(negedge clk_sys);
    ev = '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [11:0] adr [16] = '{12'hF00, 12'hF01, 12'hF02, 12'hF03, 12'hF04,
      12'hF05, 12'hF10, 12'hF11, 12'hF12, 12'hF13, 12'hF14, 12'hF15,
      12'hF26, 12'hF27, 12'hF30, 12'hF31};
    foreach (adr[i]) rdchk(adr[i], 4'h0);
    check({11'h000, irq_ff}, 12'h000);
  endtask

  // Every flag set at once; clock, stopwatch and input group one flags read twice: second read sees them cleared
  task automatic t_flags;
    pulse(irq_ev_t'(10'h3FF));
    rdchk(`ADR_CLK_FLAGS, 4'hF);
    check({10'h000, rvalid_ff, hit_ff}, 12'h003);
    rdchk(`ADR_CLK_FLAGS, 4'h0);
    rdchk(`ADR_SW_FLAGS, 4'h3);
    rdchk(`ADR_SW_FLAGS, 4'h0);
    rdchk(`ADR_PT_FLAG, 4'h1);
    rdchk(`ADR_SIO_FLAG, 4'h1);
    rdchk(`ADR_K0_FLAG, 4'h1);
    rdchk(`ADR_K1_FLAG, 4'h1);
    rdchk(`ADR_K1_FLAG, 4'h0);
  endtask

  // All ones written: only implemented mask bits come back
  task automatic t_masks;
    logic [11:0] adr [6] = '{12'hF10, 12'hF11, 12'hF12, 12'hF13, 12'hF14,
      12'hF15};
    logic [3:0] imp [6] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'hF, 4'hF};
    foreach (adr[i]) begin
      wr(adr[i], 4'hF);
      rdchk(adr[i], imp[i]);
      wr(adr[i], 4'h0);
      rdchk(adr[i], 4'h0);
    end
    wr(`ADR_CLK_FLAGS, 4'hF);
    rdchk(`ADR_CLK_FLAGS, 4'h0);
  endtask

  task automatic t_readouts;
    divider = 8'hA5;
    sw_hund = 4'h9;
    sw_tenth = 4'h7;
    pt_count = 8'h3C;
    k0_pins = 4'hB;
    wr(`ADR_DIV_HIGH, 4'h0);
    rdchk(`ADR_DIV_HIGH, 4'h5);
    rdchk(`ADR_DIV_LOW, 4'hA);
    rdchk(`ADR_SW_HUND, 4'h9);
    rdchk(`ADR_SW_TENTH, 4'h7);
    rdchk(`ADR_PT_CNT_LO, 4'hC);
    rdchk(`ADR_PT_CNT_HI, 4'h3);
    rdchk(`ADR_K0_LEVELS, 4'hB);
  endtask

  // Nibble pairs, shifter load, and misses inside and beyond the bank
  task automatic t_data;
    wr(`ADR_PT_RLD_LO, 4'h6);
    wr(`ADR_PT_RLD_HI, 4'h9);
    check({4'h0, pt_reload_ff}, 12'h096);
    rdchk(`ADR_PT_RLD_HI, 4'h9);
    wr(`ADR_SIO_LO, 4'hA);
    wr(`ADR_SIO_HI, 4'h5);
    rdchk(`ADR_SIO_LO, 4'hA);
    @(negedge clk_sys);
    sio_load = 8'hC3;
    sio_load_en = 1'b1;
    @(negedge clk_sys);
    sio_load_en = 1'b0;
    check({4'h0, sio_data_ff}, 12'h0C3);
    rdchk(`ADR_SIO_HI, 4'hC);
    rdchk(12'hFC0, 4'h0);
    check({11'h000, hit_ff}, 12'h000);
    rdchk(12'hF06, 4'h0);
    // Pin change: a masked pin is ignored, an enabled one flags the group
    wr(`ADR_K0_MASK, 4'h1);
    k0_pins = 4'h9;
    rdchk(`ADR_K0_FLAG, 4'h0);
    k0_pins = 4'h8;
    rdchk(`ADR_K0_FLAG, 4'h1);
    rdchk(`ADR_K0_FLAG, 4'h0);
    wr(`ADR_K0_MASK, 4'h0);
  endtask

  // Each source alone gives its vector; coinciding ones pick the highest
  task automatic t_irq;
    irq_ev_t evs [6] = '{10'h040, 10'h010, 10'h002, 10'h001, 10'h004,
      10'h008};
    logic [11:0] adr [6] = '{12'hF00, 12'hF01, 12'hF04, 12'hF05, 12'hF03,
      12'hF02};
    foreach (adr[i]) wr(12'hF10 + 12'(i), 4'hF);
    foreach (evs[i]) begin
      pulse(evs[i]);
      @(negedge clk_sys);
      check(irq_vec_ff, `VEC_CLOCK + 12'(2 * i));
      rdchk(adr[i], 4'h1);
      @(negedge clk_sys);
      check({11'h000, irq_ff}, 12'h000);
    end
    pulse(irq_ev_t'(10'h048));
    @(negedge clk_sys);
    check(irq_vec_ff, `VEC_PROG_TIMER);
    rdchk(`ADR_PT_FLAG, 4'h1);
    @(negedge clk_sys);
    check(irq_vec_ff, `VEC_CLOCK);
    wr(`ADR_CLK_MASK, 4'h0);
    @(negedge clk_sys);
    check({11'h000, irq_ff}, 12'h000);
    rdchk(`ADR_CLK_FLAGS, 4'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; 5000 leaves wide margin
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    req = '0;
    ev = '0;
    divider = 8'h00;
    sw_hund = 4'h0;
    sw_tenth = 4'h0;
    pt_count = 8'h00;
    sio_load = 8'h00;
    sio_load_en = 1'b0;
    k0_pins = 4'h0;
    k1_pins = 4'h0;
    num_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_flags();
    t_masks();
    t_readouts();
    t_data();
    t_irq();
    tally_and_finish();
  end
endmodule
